// ### inc/actuator_regs_pkg.sv
// Register map, codes and limits of the actuator operation register bank.
// Assumes word addressing from zero, one 16-bit word per address.
package actuator_regs_pkg;

    // Word addresses
    localparam logic [15:0] ADDR_SETPOINT  = 16'h0000;
    localparam logic [15:0] ADDR_OVERRIDE  = 16'h0001;
    localparam logic [15:0] ADDR_COMMAND   = 16'h0002;
    localparam logic [15:0] ADDR_ACT_TYPE  = 16'h0003;
    localparam logic [15:0] ADDR_REL_POS   = 16'h0004;
    localparam logic [15:0] ADDR_ABS_POS   = 16'h0005;
    localparam logic [15:0] ADDR_SENSOR    = 16'h0008;
    localparam logic [15:0] ADDR_ANALOG_SP = 16'h000C;

    // Reset values
    localparam logic [15:0] SETPOINT_RESET = 16'h0000;
    localparam logic [15:0] OVERRIDE_RESET = 16'h0000;
    localparam logic [15:0] COMMAND_RESET  = 16'h0000;

    // Value limits
    localparam logic [15:0] PERCENT_FULL   = 16'h2710;
    localparam logic [31:0] PERCENT_DIV    = 32'h0000_2710;
    localparam logic [15:0] NOT_SUPPORTED  = 16'hFFFF;
    localparam logic [15:0] ACT_TYPE_MAX   = 16'h0005;
    localparam logic [15:0] SWITCH_ON      = 16'h0001;
    localparam logic [15:0] SWITCH_OFF     = 16'h0000;

    // Override selections
    typedef enum logic [15:0] {
        OVR_NONE       = 16'h0000,
        OVR_OPEN       = 16'h0001,
        OVR_CLOSE      = 16'h0002,
        OVR_MIN        = 16'h0003,
        OVR_MID        = 16'h0004,
        OVR_MAX        = 16'h0005,
        OVR_FAST_OPEN  = 16'h0006,
        OVR_FAST_CLOSE = 16'h0007
    } override_t;

    // Service commands
    typedef enum logic [15:0] {
        CMD_NONE     = 16'h0000,
        CMD_ADAPTION = 16'h0001,
        CMD_TEST     = 16'h0002,
        CMD_SYNC     = 16'h0003,
        CMD_RESET    = 16'h0004
    } command_t;

    // Action pulse bit positions
    localparam int PULSE_ADAPTION = 0;
    localparam int PULSE_TEST     = 1;
    localparam int PULSE_SYNC     = 2;
    localparam int PULSE_DIAG     = 3;
    localparam int PULSE_COUNT    = 4;

    // Sensor type codes
    localparam logic [15:0] SENSOR_ACTIVE           = 16'h0001;
    localparam logic [15:0] LOW_OHM_RESISTIVE_TYPE  = 16'h0002;
    localparam logic [15:0] HIGH_OHM_RESISTIVE_TYPE = 16'h0003;
    localparam logic [15:0] SENSOR_SWITCH           = 16'h0004;
    localparam logic [15:0] PLATINUM_PROBE_CELSIUS  = 16'h0005;
    localparam logic [15:0] THERMISTOR_PROBE_FAHRENHEIT = 16'h000A;

endpackage

// ### logic/actuator_operation_register_bank.sv
// Operation register bank of a valve or damper actuator.
// Assumes a frame decoder ahead of it that splits function codes 3, 6 and 16
// into single word accesses, and actuator logic that supplies live values.
`timescale 1ns/1ps

module actuator_operation_register_bank
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Word access from the frame decoder
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic [15:0] acc_addr,
    input  wire logic [15:0] acc_wdata,
    output logic      [15:0] acc_rdata,
    output logic             acc_done,
    // Live actuator values
    input  wire logic [15:0] actuator_type,
    input  wire logic [15:0] relative_position,
    input  wire logic [15:0] absolute_position,
    input  wire logic [15:0] sensor_kind,
    input  wire logic [15:0] sensor_raw,
    input  wire logic        analog_active,
    input  wire logic [15:0] analog_setpoint,
    // Configured travel limits
    input  wire logic [15:0] limit_min,
    input  wire logic [15:0] limit_max,
    // Drive control
    output logic      [15:0] position_target,
    output logic      [15:0] override_mode,
    output logic             start_adaption,
    output logic             start_test,
    output logic             start_sync,
    output logic             clear_diagnostics
);

    typedef struct packed {
        logic [15:0] position_setpoint;
        logic [15:0] override_control;
        logic [15:0] service_command;
        logic [15:0] rdata;
        logic        done;
        logic [actuator_regs_pkg::PULSE_COUNT-1:0] pulse;
        logic [15:0] target;
    } state_t;

    state_t st;
    state_t next_st;

    logic [15:0] span;
    logic [31:0] scaled;
    logic [31:0] offset;
    logic        wr;

    // Only the three control words take writes
    function automatic logic writable(input logic [15:0] a);
        writable = (a == actuator_regs_pkg::ADDR_SETPOINT) ||
                   (a == actuator_regs_pkg::ADDR_OVERRIDE) ||
                   (a == actuator_regs_pkg::ADDR_COMMAND);
    endfunction

    // Sensor word depends on the configured sensor type
    function automatic logic [15:0] sensor_word(input logic [15:0] kind,
                                                input logic [15:0] raw);
        if (kind == actuator_regs_pkg::SENSOR_ACTIVE)
            sensor_word = raw;
        else if (kind == actuator_regs_pkg::LOW_OHM_RESISTIVE_TYPE ||
                 kind == actuator_regs_pkg::HIGH_OHM_RESISTIVE_TYPE)
            sensor_word = raw;
        else if (kind == actuator_regs_pkg::SENSOR_SWITCH)
            sensor_word = (raw != 16'h0000) ? actuator_regs_pkg::SWITCH_ON
                                            : actuator_regs_pkg::SWITCH_OFF;
        else if (kind >= actuator_regs_pkg::PLATINUM_PROBE_CELSIUS &&
                 kind <= actuator_regs_pkg::THERMISTOR_PROBE_FAHRENHEIT)
            sensor_word = raw;
        else
            sensor_word = actuator_regs_pkg::NOT_SUPPORTED;
    endfunction

    assign wr = acc_valid && acc_write;

    // Inverted limits give no travel rather than a wrapped span
    assign span   = (limit_max > limit_min) ? (limit_max - limit_min) : 16'h0000;
    assign scaled = 32'(st.position_setpoint) * 32'(span);
    assign offset = scaled / actuator_regs_pkg::PERCENT_DIV;

    always_comb
    begin
        next_st        = st;
        next_st.done   = 1'b0;
        next_st.pulse  = '0;
        next_st.target = limit_min + offset[15:0];

        // Command stays visible one cycle, then fires and returns to none
        if (st.service_command != actuator_regs_pkg::CMD_NONE)
        begin
            next_st.service_command = actuator_regs_pkg::COMMAND_RESET;
            case (st.service_command)
                actuator_regs_pkg::CMD_ADAPTION:
                    next_st.pulse[actuator_regs_pkg::PULSE_ADAPTION] = 1'b1;
                actuator_regs_pkg::CMD_TEST:
                    next_st.pulse[actuator_regs_pkg::PULSE_TEST] = 1'b1;
                actuator_regs_pkg::CMD_SYNC:
                    next_st.pulse[actuator_regs_pkg::PULSE_SYNC] = 1'b1;
                actuator_regs_pkg::CMD_RESET:
                    next_st.pulse[actuator_regs_pkg::PULSE_DIAG] = 1'b1;
                default:
                    next_st.pulse = '0;
            endcase
        end

        if (acc_valid)
        begin
            next_st.done = 1'b1;
            next_st.rdata = actuator_regs_pkg::NOT_SUPPORTED;
            case (acc_addr)
                actuator_regs_pkg::ADDR_SETPOINT:
                    next_st.rdata = st.position_setpoint;
                actuator_regs_pkg::ADDR_OVERRIDE:
                    next_st.rdata = st.override_control;
                actuator_regs_pkg::ADDR_COMMAND:
                    next_st.rdata = st.service_command;
                actuator_regs_pkg::ADDR_ACT_TYPE:
                    if (actuator_type <= actuator_regs_pkg::ACT_TYPE_MAX)
                        next_st.rdata = actuator_type;
                actuator_regs_pkg::ADDR_REL_POS:
                    if (relative_position <= actuator_regs_pkg::PERCENT_FULL)
                        next_st.rdata = relative_position;
                actuator_regs_pkg::ADDR_ABS_POS:
                    next_st.rdata = absolute_position;
                actuator_regs_pkg::ADDR_SENSOR:
                    next_st.rdata = sensor_word(sensor_kind, sensor_raw);
                actuator_regs_pkg::ADDR_ANALOG_SP:
                    if (analog_active && analog_setpoint <= actuator_regs_pkg::PERCENT_FULL)
                        next_st.rdata = analog_setpoint;
                default:
                    next_st.rdata = actuator_regs_pkg::NOT_SUPPORTED;
            endcase
            // Writes answer with the word held before the write; out-of-range values are dropped
            if (acc_write)
            begin
                case (acc_addr)
                    actuator_regs_pkg::ADDR_SETPOINT:
                        if (acc_wdata <= actuator_regs_pkg::PERCENT_FULL)
                            next_st.position_setpoint = acc_wdata;
                    actuator_regs_pkg::ADDR_OVERRIDE:
                        if (acc_wdata <= actuator_regs_pkg::OVR_FAST_CLOSE)
                            next_st.override_control = acc_wdata;
                    actuator_regs_pkg::ADDR_COMMAND:
                        if (acc_wdata <= actuator_regs_pkg::CMD_RESET)
                            next_st.service_command = acc_wdata;
                    default:
                        next_st.override_control = st.override_control;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st                   <= '0;
            st.position_setpoint <= actuator_regs_pkg::SETPOINT_RESET;
            st.override_control  <= actuator_regs_pkg::OVERRIDE_RESET;
            st.service_command   <= actuator_regs_pkg::COMMAND_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Straight from the state flops
    assign acc_rdata         = st.rdata;
    assign acc_done          = st.done;
    assign position_target   = st.target;
    assign override_mode     = st.override_control;
    assign start_adaption    = st.pulse[actuator_regs_pkg::PULSE_ADAPTION];
    assign start_test        = st.pulse[actuator_regs_pkg::PULSE_TEST];
    assign start_sync        = st.pulse[actuator_regs_pkg::PULSE_SYNC];
    assign clear_diagnostics = st.pulse[actuator_regs_pkg::PULSE_DIAG];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_SP_RANGE: assert property (
        st.position_setpoint <= actuator_regs_pkg::PERCENT_FULL)
        else $error("setpoint above full scale");

    AST_SP_WRITE: assert property (
        wr && acc_addr == actuator_regs_pkg::ADDR_SETPOINT
        && acc_wdata <= actuator_regs_pkg::PERCENT_FULL
        |=> st.position_setpoint == $past(acc_wdata))
        else $error("setpoint write not stored");

    AST_SP_REFUSE: assert property (
        wr && acc_addr == actuator_regs_pkg::ADDR_SETPOINT
        && acc_wdata > actuator_regs_pkg::PERCENT_FULL
        |=> $stable(st.position_setpoint))
        else $error("setpoint above full scale accepted");

    AST_SP_READ: assert property (
        acc_valid && !acc_write && acc_addr == actuator_regs_pkg::ADDR_SETPOINT
        |=> acc_rdata == $past(st.position_setpoint))
        else $error("setpoint read back wrong");

    AST_TARGET_RANGE: assert property (
        limit_max > limit_min
        |=> position_target >= $past(limit_min) && position_target <= $past(limit_max))
        else $error("target outside the travel limits");

    AST_TARGET_FLAT: assert property (
        limit_max <= limit_min
        |=> position_target == $past(limit_min))
        else $error("target moved with no travel span");

    AST_OVR_WRITE: assert property (
        wr && acc_addr == actuator_regs_pkg::ADDR_OVERRIDE
        && acc_wdata <= actuator_regs_pkg::OVR_FAST_CLOSE
        |=> override_mode == $past(acc_wdata))
        else $error("override write not stored");

    AST_OVR_RANGE: assert property (
        wr && acc_addr == actuator_regs_pkg::ADDR_OVERRIDE
        && acc_wdata > actuator_regs_pkg::OVR_FAST_CLOSE
        |=> $stable(st.override_control))
        else $error("bad override accepted");

    AST_CMD_ACTION: assert property (
        wr && acc_addr == actuator_regs_pkg::ADDR_COMMAND
        && acc_wdata == actuator_regs_pkg::CMD_ADAPTION
        |=> ##1 start_adaption)
        else $error("adaption not started");

    AST_CMD_TEST: assert property (
        wr && acc_addr == actuator_regs_pkg::ADDR_COMMAND
        && acc_wdata == actuator_regs_pkg::CMD_TEST
        |=> ##1 start_test)
        else $error("test run not started");

    AST_CMD_SYNC: assert property (
        wr && acc_addr == actuator_regs_pkg::ADDR_COMMAND
        && acc_wdata == actuator_regs_pkg::CMD_SYNC
        |=> ##1 start_sync)
        else $error("synchronisation not started");

    AST_CMD_REFUSE: assert property (
        wr && acc_addr == actuator_regs_pkg::ADDR_COMMAND
        && acc_wdata > actuator_regs_pkg::CMD_RESET
        |=> st.service_command == actuator_regs_pkg::CMD_NONE)
        else $error("bad command accepted");

    AST_CMD_CLEAR: assert property (
        st.service_command != actuator_regs_pkg::CMD_NONE
        |=> st.service_command == actuator_regs_pkg::CMD_NONE
            || $past(wr && acc_addr == actuator_regs_pkg::ADDR_COMMAND))
        else $error("command not returned to none");

    AST_PULSE_CAUSE: assert property (
        st.pulse != '0
        |-> $past(st.service_command != actuator_regs_pkg::CMD_NONE))
        else $error("action started without a command");

    AST_DIAG: assert property (
        wr && acc_addr == actuator_regs_pkg::ADDR_COMMAND
        && acc_wdata == actuator_regs_pkg::CMD_RESET
        |=> !clear_diagnostics ##1 clear_diagnostics ##1 !clear_diagnostics)
        else $error("diagnostics clear not a single pulse");

    AST_TYPE: assert property (
        acc_valid && !acc_write && acc_addr == actuator_regs_pkg::ADDR_ACT_TYPE
        && actuator_type > actuator_regs_pkg::ACT_TYPE_MAX
        |=> acc_rdata == actuator_regs_pkg::NOT_SUPPORTED)
        else $error("bad type code shown");

    AST_ABS: assert property (
        acc_valid && acc_addr == actuator_regs_pkg::ADDR_ABS_POS
        |=> acc_rdata == $past(absolute_position))
        else $error("absolute position read back wrong");

    AST_SENSOR_PASS: assert property (
        acc_valid && acc_addr == actuator_regs_pkg::ADDR_SENSOR
        && sensor_kind == actuator_regs_pkg::SENSOR_ACTIVE
        |=> acc_rdata == $past(sensor_raw))
        else $error("active sensor value not passed");

    AST_SWITCH: assert property (
        acc_valid && acc_addr == actuator_regs_pkg::ADDR_SENSOR
        && sensor_kind == actuator_regs_pkg::SENSOR_SWITCH
        |=> acc_done && acc_rdata <= actuator_regs_pkg::SWITCH_ON)
        else $error("switch sensor not 0 or 1");

    AST_ANALOG: assert property (
        acc_valid && acc_addr == actuator_regs_pkg::ADDR_ANALOG_SP
        && !analog_active
        |=> acc_rdata == actuator_regs_pkg::NOT_SUPPORTED)
        else $error("analog setpoint shown while inactive");

    AST_ANALOG_PASS: assert property (
        acc_valid && acc_addr == actuator_regs_pkg::ADDR_ANALOG_SP && analog_active
        && analog_setpoint <= actuator_regs_pkg::PERCENT_FULL
        |=> acc_rdata == $past(analog_setpoint))
        else $error("analog setpoint not shown while active");

    AST_REL: assert property (
        acc_valid && acc_addr == actuator_regs_pkg::ADDR_REL_POS
        && relative_position <= actuator_regs_pkg::PERCENT_FULL
        |=> acc_rdata == $past(relative_position))
        else $error("relative position read back wrong");

    AST_RO_HOLD: assert property (
        wr && !writable(acc_addr)
        |=> $stable(st.position_setpoint)
            && $stable(st.override_control))
        else $error("read-only or reserved write changed state");

    AST_RESERVED: assert property (
        acc_valid && ((acc_addr > actuator_regs_pkg::ADDR_ABS_POS && acc_addr < actuator_regs_pkg::ADDR_SENSOR)
        || (acc_addr > actuator_regs_pkg::ADDR_SENSOR && acc_addr < actuator_regs_pkg::ADDR_ANALOG_SP))
        |=> acc_rdata == actuator_regs_pkg::NOT_SUPPORTED)
        else $error("reserved address did not read as all ones");

    AST_UNSUP: assert property (
        acc_valid && acc_addr == actuator_regs_pkg::ADDR_SENSOR
        && sensor_kind < actuator_regs_pkg::SENSOR_ACTIVE
        |=> acc_rdata == actuator_regs_pkg::NOT_SUPPORTED)
        else $error("unsupported sensor not shown as all ones");

    AST_DONE: assert property (
        acc_valid |=> acc_done)
        else $error("access not answered");

    COV_SETPOINT: cover property (
        wr && acc_addr == actuator_regs_pkg::ADDR_SETPOINT ##1 acc_done);
    COV_OVERRIDE: cover property (
        wr && acc_addr == actuator_regs_pkg::ADDR_OVERRIDE && acc_wdata == actuator_regs_pkg::OVR_FAST_CLOSE);
    COV_COMMAND:  cover property (start_sync);
    COV_SENSOR:   cover property (
        acc_valid && acc_addr == actuator_regs_pkg::ADDR_SENSOR ##1 acc_done);

endmodule // actuator_operation_register_bank

// ### test/access_master.sv
// Bus master model: issues single word accesses to the register bank.
// Assumes the bank takes a request every cycle and answers one cycle later.
`timescale 1ns/1ps

module access_master
(
    // Clock
    input  wire logic        core_clk,
    // Word access
    output logic             acc_valid,
    output logic             acc_write,
    output logic      [15:0] acc_addr,
    output logic      [15:0] acc_wdata,
    input  wire logic [15:0] acc_rdata,
    input  wire logic        acc_done
);
    initial
    begin
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_addr  = 16'h0000;
        acc_wdata = 16'h0000;
    end

    // One holding-register word at the address handed in
    // Fast override codes go out only when a scenario hands them over
    // Idle lines carry the inverse so a stale value never passes for fresh
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok);
        @(posedge core_clk);
        acc_valid <= 1'b1;
        acc_write <= wr;
        acc_addr  <= addr;
        acc_wdata <= wd;
        @(posedge core_clk);
        acc_valid <= 1'b0;
        acc_addr  <= ~addr;
        acc_wdata <= ~wd;
        #1;
        ok = acc_done;
        rd = acc_rdata;
    endtask
endmodule // access_master

// ### test/actuator_operation_register_bank_tb.sv
// Self-checking bench for the actuator operation register bank.
// Assumes the access master model drives the word access port.
`timescale 1ns/1ps

module actuator_operation_register_bank_tb;
    logic core_clk, rst, acc_valid, acc_write, acc_done, analog_active;
    logic [15:0] acc_addr, acc_wdata, acc_rdata, actuator_type, relative_position;
    logic [15:0] absolute_position, sensor_kind, sensor_raw, analog_setpoint;
    logic [15:0] limit_min, limit_max, position_target, override_mode;
    logic start_adaption, start_test, start_sync, clear_diagnostics;
    logic [3:0] pulses;
    int miscompares, n_checks, cycles;

    assign pulses = {clear_diagnostics, start_sync, start_test, start_adaption};

    actuator_operation_register_bank u_actuator_operation_register_bank
    (.core_clk(core_clk), .rst(rst), .acc_valid(acc_valid), .acc_write(acc_write),
     .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
     .acc_done(acc_done), .actuator_type(actuator_type),
     .relative_position(relative_position), .absolute_position(absolute_position),
     .sensor_kind(sensor_kind), .sensor_raw(sensor_raw), .analog_active(analog_active),
     .analog_setpoint(analog_setpoint), .limit_min(limit_min), .limit_max(limit_max),
     .position_target(position_target), .override_mode(override_mode),
     .start_adaption(start_adaption), .start_test(start_test), .start_sync(start_sync),
     .clear_diagnostics(clear_diagnostics));

    access_master u_access_master
    (.core_clk(core_clk), .acc_valid(acc_valid), .acc_write(acc_write),
     .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
     .acc_done(acc_done));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic results();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        u_access_master.xfer(1'b0, a, 16'h0000, d, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(d, exp);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        logic [15:0] d;
        logic ok;
        u_access_master.xfer(1'b1, a, v, d, ok);
        chk({15'h0000, ok}, 16'h0001);
    endtask

    task automatic t_setpoint();
        rd(16'h0000, 16'h0000);
        rd(16'h0001, 16'h0000);
        rd(16'h0002, 16'h0000);
        wr(16'h0000, 16'h1388);
        @(posedge core_clk); #1;
        chk(position_target, 16'h1388);
        wr(16'h0000, 16'h2710);
        @(posedge core_clk); #1;
        chk(position_target, 16'h2328);
        wr(16'h0000, 16'h2711);
        rd(16'h0000, 16'h2710);
    endtask

    task automatic t_override();
        for (int i = 0; i < 8; i++)
        begin
            wr(16'h0001, 16'(i));
            rd(16'h0001, 16'(i));
            chk(override_mode, 16'(i));
        end
        wr(16'h0001, 16'h0008);
        rd(16'h0001, 16'h0007);
    endtask

    // Codes 1 to 4 each pulse their own action once and code 5 pulses none, then the register reads none
    task automatic t_command();
        for (int c = 1; c < 6; c++)
        begin
            wr(16'h0002, 16'(c));
            chk({12'h000, pulses}, 16'h0000);
            @(posedge core_clk); #1;
            chk({12'h000, pulses}, (c < 5) ? 16'(1 << (c - 1)) : 16'h0000);
            rd(16'h0002, 16'h0000);
            chk({12'h000, pulses}, 16'h0000);
        end
    endtask

    task automatic t_live();
        for (int i = 0; i < 7; i++)
        begin
            @(posedge core_clk);
            actuator_type <= 16'(i);
            rd(16'h0003, (i > 5) ? 16'hFFFF : 16'(i));
        end
        @(posedge core_clk);
        relative_position <= 16'h2710;
        absolute_position <= 16'hBEEF;
        wr(16'h0004, 16'h0001);
        wr(16'h0005, 16'h0002);
        wr(16'h0003, 16'h0003);
        rd(16'h0004, 16'h2710);
        rd(16'h0005, 16'hBEEF);
        rd(16'h0003, 16'hFFFF);
        @(posedge core_clk);
        relative_position <= 16'h2711;
        analog_active <= 1'b1;
        rd(16'h0004, 16'hFFFF);
        rd(16'h000C, 16'h1234);
        @(posedge core_clk);
        analog_active <= 1'b0;
        rd(16'h000C, 16'hFFFF);
    endtask

    // Kinds 0 and 11 are unsupported; kind 4 folds the raw value to a switch state
    task automatic t_sensor();
        for (int k = 0; k < 12; k++)
        begin
            @(posedge core_clk);
            sensor_kind <= 16'(k);
            rd(16'h0008, (k == 0 || k > 10) ? 16'hFFFF : (k == 4) ? 16'h0001 : 16'hA5A5);
        end
        @(posedge core_clk);
        sensor_kind <= 16'h0004;
        sensor_raw  <= 16'h0000;
        rd(16'h0008, 16'h0000);
    endtask

    task automatic t_reserved();
        logic [15:0] a[5] = '{16'h0006, 16'h0007, 16'h0009, 16'h000A, 16'h000B};
        foreach (a[i])
        begin
            wr(a[i], 16'h5555);
            rd(a[i], 16'hFFFF);
        end
        rd(16'h0000, 16'h2710);
        rd(16'h0001, 16'h0007);
        rd(16'h0002, 16'h0000);
    endtask

    // Inverted limits leave no travel, so the target rests on the lower limit
    task automatic t_limits();
        @(posedge core_clk);
        limit_min <= 16'h1388;
        limit_max <= 16'h0FA0;
        repeat (2) @(posedge core_clk);
        #1;
        chk(position_target, 16'h1388);
        @(posedge core_clk);
        limit_min <= 16'h0000;
        limit_max <= 16'h2710;
        repeat (2) @(posedge core_clk);
        #1;
        chk(position_target, 16'h2710);
    endtask

    // A second reset mid-run must bring the control words back to their defaults
    task automatic t_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(16'h0000, 16'h0000);
        rd(16'h0001, 16'h0000);
        rd(16'h0002, 16'h0000);
        chk(override_mode, 16'h0000);
        chk(position_target, 16'h0000);
    endtask

    // Runs take a few hundred cycles; the ceiling only cuts a hang
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            miscompares++;
            results();
        end
    end

    initial
    begin
        rst = 1'b1;
        cycles = 0;
        miscompares = 0;
        n_checks = 0;
        actuator_type = 16'h0001;
        relative_position = 16'h0000;
        absolute_position = 16'h0000;
        sensor_kind = 16'h0001;
        sensor_raw = 16'hA5A5;
        analog_active = 1'b0;
        analog_setpoint = 16'h1234;
        limit_min = 16'h03E8;
        limit_max = 16'h2328;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk); #1;
        chk(position_target, 16'h03E8);
        t_setpoint();
        t_override();
        t_command();
        t_live();
        t_sensor();
        t_reserved();
        t_limits();
        t_reset();
        results();
    end
endmodule // actuator_operation_register_bank_tb
